// ==== design/acrc_pkg.sv ====
`default_nettype none

package acrc_pkg;

  // ****************************************************************
  // Clock and word layout
  // ****************************************************************
  localparam real        CLK_PERIOD_NS  = 20.0;
  localparam int         RESULT_W       = 24;
  localparam int         SAMPLE_W       = 32;
  localparam int         TIMER_W        = 32;
  localparam logic [4:0] BITS_PER_WORD  = 5'h18;
  localparam logic [4:0] FORCE_PULSE    = 5'h19;
  localparam logic [4:0] CAL_PULSE      = 5'h1a;
  localparam logic [4:0] BIT_CNT_FIRST  = 5'h00;
  localparam logic [23:0] RESULT_POS_FS = 24'h7fffff;
  localparam logic [23:0] RESULT_NEG_FS = 24'h800000;

  // ****************************************************************
  // Synchroniser lanes on the device side
  // ****************************************************************
  localparam int SYNC_START = 0;
  localparam int SYNC_MODE  = 1;
  localparam int SYNC_SCLK  = 2;
  localparam int SYNC_W     = 3;

  // ****************************************************************
  // Times as printed and their cycle counts
  // ****************************************************************
  localparam real HS_CONV_MIN_MS     = 8.0;
  localparam real HS_CONV_MAX_MS     = 13.3;
  localparam real HR_CONV_MIN_MS     = 45.5;
  localparam real HR_CONV_MAX_MS     = 83.3;
  localparam real CAL_MIN_MS         = 187.0;
  localparam real CAL_MAX_MS         = 313.0;
  localparam real UPDATE_MIN_US      = 29.5;
  localparam real UPDATE_MAX_US      = 49.2;
  localparam real START_PULSE_MIN_US = 17.0;
  localparam real SCLK_PULSE_MIN_NS  = 100.0;

  localparam int HS_CONV_CYC     = int'($ceil(HS_CONV_MIN_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int HS_CONV_MAX_CYC = int'($floor(HS_CONV_MAX_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int HR_CONV_CYC     = int'($ceil(HR_CONV_MIN_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int HR_CONV_MAX_CYC = int'($floor(HR_CONV_MAX_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int CAL_CYC         = int'($ceil(CAL_MIN_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int CAL_MAX_CYC     = int'($floor(CAL_MAX_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int UPDATE_CYC      = int'($ceil(UPDATE_MIN_US * 1.0e3 / CLK_PERIOD_NS));
  localparam int UPDATE_MAX_CYC  = int'($floor(UPDATE_MAX_US * 1.0e3 / CLK_PERIOD_NS));
  localparam int START_PULSE_CYC = int'($ceil(START_PULSE_MIN_US * 1.0e3 / CLK_PERIOD_NS));
  // Double the minimum so the far end's two-stage synchroniser settles
  localparam int SCLK_HALF_CYC   = 2 * int'($ceil(SCLK_PULSE_MIN_NS / CLK_PERIOD_NS));

  // ****************************************************************
  // State types
  // ****************************************************************
  typedef enum logic [1:0] {
    DEV_CAL,
    DEV_OFF,
    DEV_CONV,
    DEV_UPDATE
  } acrc_dev_state_t;

  typedef enum logic [1:0] {
    HOST_IDLE,
    HOST_WAIT,
    HOST_HIGH,
    HOST_LOW
  } acrc_host_state_t;

endpackage : acrc_pkg

`default_nettype wire

// ==== design/acrc_link_if.sv ====
`default_nettype none

interface acrc_link_if;
  logic start;
  logic mode;
  logic sclk;
  logic ready_and_serial_output;

  modport dev (
    input  start,
    input  mode,
    input  sclk,
    output ready_and_serial_output
  );

  modport host (
    output start,
    output mode,
    output sclk,
    input  ready_and_serial_output
  );
endinterface : acrc_link_if

`default_nettype wire

// ==== design/acrc_device.sv ====
`default_nettype none

module acrc_device
  import acrc_pkg::*;
#(
  parameter int HS_CONV_CYCLES = HS_CONV_CYC,
  parameter int HR_CONV_CYCLES = HR_CONV_CYC,
  parameter int CAL_CYCLES     = CAL_CYC
) (
  // System
  input  wire logic                       clock,
  input  wire logic                       srst,
  // Link to the host
  acrc_link_if.dev                        link,
  // Modelled analog input, already scaled to result steps
  input  wire logic signed [SAMPLE_W-1:0] sample_in,
  // Status
  output logic                            converting,
  output logic                            calibrating,
  output logic                            powered_down
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [SYNC_W-1:0] meta_reg;
  logic [SYNC_W-1:0] sync_reg;
  logic              sclk_prev_reg;

  always_ff @(posedge clock) begin
    if (srst) begin
      meta_reg      <= '0;
      sync_reg      <= '0;
      sclk_prev_reg <= 1'b0;
    end else begin
      meta_reg      <= {link.sclk, link.mode, link.start};
      sync_reg      <= meta_reg;
      sclk_prev_reg <= sync_reg[SYNC_SCLK];
    end
  end

  wire logic start_s   = sync_reg[SYNC_START];
  wire logic mode_s    = sync_reg[SYNC_MODE];
  wire logic sclk_s    = sync_reg[SYNC_SCLK];
  wire logic sclk_rise = sclk_s & ~sclk_prev_reg;
  wire logic sclk_fall = ~sclk_s & sclk_prev_reg;

  // ****************************************************************
  // State
  // ****************************************************************
  acrc_dev_state_t       state_reg;
  acrc_dev_state_t       state_next;
  logic [TIMER_W-1:0]    timer_reg;
  logic [TIMER_W-1:0]    timer_next;
  logic                  fast_reg;
  logic                  fast_next;
  logic [RESULT_W-1:0]   shift_reg;
  logic [RESULT_W-1:0]   shift_next;
  logic [4:0]            bit_cnt_reg;
  logic [4:0]            bit_cnt_next;
  logic                  dout_reg;
  logic                  dout_next;
  logic                  converting_reg;
  logic                  calibrating_reg;
  logic                  powered_down_reg;

  // ****************************************************************
  // Result shaping
  // ****************************************************************
  // Anything past full scale clips instead of wrapping
  wire logic signed [SAMPLE_W-1:0] pos_limit =
    $signed({{(SAMPLE_W-RESULT_W){1'b0}}, RESULT_POS_FS});
  wire logic signed [SAMPLE_W-1:0] neg_limit =
    $signed({{(SAMPLE_W-RESULT_W){1'b1}}, RESULT_NEG_FS});
  wire logic pos_over = (sample_in >= pos_limit);
  wire logic neg_over = (sample_in <= neg_limit);
  wire logic [RESULT_W-1:0] result_word =
    pos_over ? RESULT_POS_FS :
    neg_over ? RESULT_NEG_FS :
    sample_in[RESULT_W-1:0];

  // ****************************************************************
  // Timing decode
  // ****************************************************************
  wire logic [TIMER_W-1:0] conv_len =
    fast_reg ? TIMER_W'(HS_CONV_CYCLES) : TIMER_W'(HR_CONV_CYCLES);
  wire logic conv_done   = (timer_reg >= conv_len - 32'h1);
  wire logic cal_done    = (timer_reg >= TIMER_W'(CAL_CYCLES) - 32'h1);
  wire logic update_done = (timer_reg >= TIMER_W'(UPDATE_CYC) - 32'h1);

  // Shifting only while the word is stable; update and calibration ignore the clock
  wire logic shift_ok = (state_reg == DEV_OFF) || (state_reg == DEV_CONV);
  wire logic data_bit = (bit_cnt_reg < BITS_PER_WORD);
  wire logic cal_request = shift_ok && sclk_fall && (bit_cnt_reg == CAL_PULSE);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    state_next   = state_reg;
    timer_next   = timer_reg + 32'h1;
    fast_next    = fast_reg;
    shift_next   = shift_reg;
    bit_cnt_next = bit_cnt_reg;
    dout_next    = dout_reg;

    if (shift_ok && sclk_rise) begin
      if (data_bit) begin
        dout_next    = shift_reg[RESULT_W-1];
        shift_next   = {shift_reg[RESULT_W-2:0], 1'b0};
        bit_cnt_next = bit_cnt_reg + 5'h01;
      end else if (bit_cnt_reg == BITS_PER_WORD) begin
        dout_next    = 1'b1;
        bit_cnt_next = FORCE_PULSE;
      end else if (bit_cnt_reg == FORCE_PULSE) begin
        bit_cnt_next = CAL_PULSE;
      end
    end

    case (state_reg)
      DEV_CAL: begin
        // Sample input is not looked at here: inputs are disconnected
        if (cal_done) begin
          state_next = DEV_UPDATE;
          timer_next = '0;
        end
      end
      DEV_OFF: begin
        timer_next = '0;
        if (start_s) begin
          state_next = DEV_CONV;
          fast_next  = mode_s;
        end
      end
      DEV_CONV: begin
        if (conv_done) begin
          state_next = DEV_UPDATE;
          timer_next = '0;
          dout_next  = 1'b1;
        end
      end
      DEV_UPDATE: begin
        if (update_done) begin
          timer_next   = '0;
          shift_next   = result_word;
          bit_cnt_next = BIT_CNT_FIRST;
          dout_next    = 1'b0;
          if (start_s) begin
            state_next = DEV_CONV;
            fast_next  = mode_s;
          end else begin
            state_next = DEV_OFF;
          end
        end
      end
      default: begin
        state_next = DEV_CAL;
        timer_next = '0;
      end
    endcase

    // A calibration request abandons any conversion in flight
    if (cal_request) begin
      state_next = DEV_CAL;
      timer_next = '0;
      dout_next  = 1'b1;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg   <= DEV_CAL;
      timer_reg   <= '0;
      fast_reg    <= 1'b0;
      shift_reg   <= '0;
      bit_cnt_reg <= CAL_PULSE;
      dout_reg    <= 1'b1;
    end else begin
      state_reg   <= state_next;
      timer_reg   <= timer_next;
      fast_reg    <= fast_next;
      shift_reg   <= shift_next;
      bit_cnt_reg <= bit_cnt_next;
      dout_reg    <= dout_next;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      converting_reg   <= 1'b0;
      calibrating_reg  <= 1'b1;
      powered_down_reg <= 1'b0;
    end else begin
      converting_reg   <= (state_next == DEV_CONV);
      calibrating_reg  <= (state_next == DEV_CAL);
      powered_down_reg <= (state_next == DEV_OFF);
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign link.ready_and_serial_output = dout_reg;
  assign converting                   = converting_reg;
  assign calibrating                  = calibrating_reg;
  assign powered_down                 = powered_down_reg;

endmodule : acrc_device

`default_nettype wire

// ==== design/acrc_host.sv ====
`default_nettype none

module acrc_host
  import acrc_pkg::*;
(
  // System
  input  wire logic                clock,
  input  wire logic                srst,
  // Link to the converter
  acrc_link_if.host                link,
  // User controls
  input  wire logic                hold_start,
  input  wire logic                fast_mode,
  input  wire logic                single_req,
  input  wire logic                read_req,
  input  wire logic                cal_req,
  // User results
  output logic [RESULT_W-1:0]      read_data,
  output logic                     read_valid,
  output logic                     busy,
  output logic                     ready_seen
);

  // ****************************************************************
  // Pin synchroniser
  // ****************************************************************
  logic din_meta_reg;
  logic din_sync_reg;

  always_ff @(posedge clock) begin
    if (srst) begin
      din_meta_reg <= 1'b1;
      din_sync_reg <= 1'b1;
    end else begin
      din_meta_reg <= link.ready_and_serial_output;
      din_sync_reg <= din_meta_reg;
    end
  end

  // ****************************************************************
  // State
  // ****************************************************************
  acrc_host_state_t     state_reg;
  acrc_host_state_t     state_next;
  logic [15:0]          pulse_cnt_reg;
  logic [15:0]          pulse_cnt_next;
  logic [15:0]          half_reg;
  logic [15:0]          half_next;
  logic [4:0]           idx_reg;
  logic [4:0]           idx_next;
  logic [4:0]           total_reg;
  logic [4:0]           total_next;
  logic [RESULT_W-1:0]  word_reg;
  logic [RESULT_W-1:0]  word_next;
  logic                 sclk_reg;
  logic                 sclk_next;
  logic                 start_reg;
  logic                 mode_reg;
  logic                 valid_reg;
  logic                 valid_next;
  logic                 ready_reg;
  logic                 busy_reg;

  wire logic half_done  = (half_reg >= 16'(SCLK_HALF_CYC) - 16'h0001);
  wire logic last_pulse = (idx_reg + 5'h01 == total_reg);
  wire logic pulsing    = (pulse_cnt_reg != 16'h0000);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    state_next     = state_reg;
    pulse_cnt_next = pulsing ? pulse_cnt_reg - 16'h0001 : pulse_cnt_reg;
    half_next      = half_reg + 16'h0001;
    idx_next       = idx_reg;
    total_next     = total_reg;
    word_next      = word_reg;
    sclk_next      = sclk_reg;
    valid_next     = 1'b0;

    if (single_req) begin
      pulse_cnt_next = 16'(START_PULSE_CYC);
    end

    case (state_reg)
      HOST_IDLE: begin
        if (read_req || cal_req) begin
          state_next = HOST_WAIT;
          total_next = cal_req ? CAL_PULSE : FORCE_PULSE;
        end
      end
      HOST_WAIT: begin
        // High during update, so waiting for low keeps reads out of it
        if (!din_sync_reg) begin
          state_next = HOST_HIGH;
          sclk_next  = 1'b1;
          half_next  = '0;
          idx_next   = '0;
        end
      end
      HOST_HIGH: begin
        if (half_done) begin
          if (idx_reg < BITS_PER_WORD) begin
            word_next = {word_reg[RESULT_W-2:0], din_sync_reg};
          end
          state_next = HOST_LOW;
          sclk_next  = 1'b0;
          half_next  = '0;
        end
      end
      HOST_LOW: begin
        if (half_done) begin
          half_next = '0;
          if (last_pulse) begin
            // No pulses beyond the last keeps a read from reaching the calibration pulse
            state_next = HOST_IDLE;
            valid_next = 1'b1;
          end else begin
            state_next = HOST_HIGH;
            sclk_next  = 1'b1;
            idx_next   = idx_reg + 5'h01;
          end
        end
      end
      default: begin
        state_next = HOST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg     <= HOST_IDLE;
      pulse_cnt_reg <= '0;
      half_reg      <= '0;
      idx_reg       <= '0;
      total_reg     <= FORCE_PULSE;
      word_reg      <= '0;
      sclk_reg      <= 1'b0;
      start_reg     <= 1'b0;
      mode_reg      <= 1'b0;
      valid_reg     <= 1'b0;
      ready_reg     <= 1'b0;
      busy_reg      <= 1'b0;
    end else begin
      state_reg     <= state_next;
      pulse_cnt_reg <= pulse_cnt_next;
      half_reg      <= half_next;
      idx_reg       <= idx_next;
      total_reg     <= total_next;
      word_reg      <= word_next;
      sclk_reg      <= sclk_next;
      start_reg     <= hold_start | (pulse_cnt_next != 16'h0000);
      mode_reg      <= fast_mode;
      valid_reg     <= valid_next;
      ready_reg     <= ~din_sync_reg;
      busy_reg      <= (state_next != HOST_IDLE);
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign link.start = start_reg;
  assign link.mode  = mode_reg;
  assign link.sclk  = sclk_reg;
  assign read_data  = word_reg;
  assign read_valid = valid_reg;
  assign busy       = busy_reg;
  assign ready_seen = ready_reg;

endmodule : acrc_host

`default_nettype wire

// ==== verif/acrc_monitor.sv ====
`default_nettype none

module acrc_monitor
  import acrc_pkg::*;
#(
  parameter int HS_CONV_CYCLES = HS_CONV_CYC,
  parameter int HR_CONV_CYCLES = HR_CONV_CYC,
  parameter int CAL_CYCLES     = CAL_CYC
) (
  // System
  input wire logic clock,
  input wire logic srst,
  // Link wires
  input wire logic start,
  input wire logic mode,
  input wire logic sclk,
  input wire logic ready_and_serial_output
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************
  // Bounds, helpers
  // ****************
  localparam int HS_MAX  = HS_CONV_CYCLES * 133 / 80 + UPDATE_MAX_CYC + 8;
  localparam int HR_MAX  = HR_CONV_CYCLES * 833 / 455 + UPDATE_MAX_CYC + 8;
  // Wide product: the full-length calibration count overflows an int
  localparam int CAL_MAX = int'(longint'(CAL_CYCLES) * 313 / 187) + UPDATE_MAX_CYC + 64;
  logic        sclk_reg, pin_reg, cal_reg, fast_reg, slow_reg;
  logic [4:0]  age_reg, rise_reg;
  logic [31:0] high_reg, per_reg, idle_reg, stw_reg;
  wire         pin        = ready_and_serial_output;
  wire         rise_now   = sclk & ~sclk_reg;
  // A fall on a quiet link is a ready mark, never a data bit
  wire         ready_fall = pin_reg & ~pin & (age_reg == 5'h1f);

  always_ff @(posedge clock) begin
    sclk_reg <= sclk;
    pin_reg  <= srst | pin;
    age_reg  <= srst ? 5'h1f : rise_now ? 5'h00 :
                (age_reg == 5'h1f) ? age_reg : age_reg + 5'h01;
    rise_reg <= (srst | ready_fall) ? 5'h00 :
                rise_reg + {4'h0, rise_now & (rise_reg != 5'h1f)};
    cal_reg  <= srst | (~ready_fall & (cal_reg | (rise_now & (rise_reg == 5'h19))));
    high_reg <= (srst | ~pin) ? 32'h0 : high_reg + 32'h1;
    per_reg  <= (srst | ready_fall) ? 32'h1 : per_reg + 32'h1;
    idle_reg <= (srst | start) ? 32'h0 : idle_reg + 32'h1;
    stw_reg  <= (srst | ~start) ? 32'h0 : stw_reg + 32'h1;
    fast_reg <= ~srst & start & mode & (ready_fall | fast_reg);
    slow_reg <= ~srst & start & ~mode & (ready_fall | slow_reg);
  end

  // ****************
  // Assertions
  // ****************
  default clocking mon_cb @(posedge clock);
  endclocking
  default disable iff (srst);

  chk_shift_slot: assert property (
    ($changed(pin) && age_reg != 5'h1f) |-> age_reg inside {[5'h02:5'h03]})
    else $error("pin moved outside a shift slot");
  chk_first_shift: assert property (
    ($rose(sclk) && rise_reg == 5'h00) |-> !pin)
    else $error("shift began without ready");
  chk_forced_high: assert property (
    ($rose(sclk) && rise_reg == 5'h18) |-> ##4 pin [*8])
    else $error("extra pulse did not force pin high");
  chk_update_gap: assert property (
    ready_fall |-> high_reg >= UPDATE_CYC)
    else $error("update interval too short");
  chk_cal_span: assert property (
    (ready_fall && cal_reg) |-> high_reg inside {[CAL_CYCLES + UPDATE_CYC - 2:CAL_MAX]})
    else $error("calibration time out of range");
  chk_fast_period: assert property (
    (ready_fall && fast_reg && !cal_reg) |->
      per_reg inside {[HS_CONV_CYCLES + UPDATE_CYC:HS_MAX]})
    else $error("fast conversion period out of range");
  chk_slow_period: assert property (
    (ready_fall && slow_reg && !cal_reg) |->
      per_reg inside {[HR_CONV_CYCLES + UPDATE_CYC:HR_MAX]})
    else $error("slow conversion period out of range");
  chk_no_self_start: assert property (
    (ready_fall && !cal_reg) |-> idle_reg <= HR_MAX)
    else $error("result without a start request");
  chk_start_width: assert property (
    $fell(start) |-> stw_reg >= START_PULSE_CYC)
    else $error("start pulse too short");
  chk_sclk_width: assert property (
    $rose(sclk) |-> sclk [*5])
    else $error("shift clock high phase too short");

  cov_cal_ready: cover property (ready_fall && cal_reg);
  cov_fast_run: cover property (ready_fall && fast_reg);
  cov_slow_run: cover property (ready_fall && slow_reg);
endmodule : acrc_monitor

`default_nettype wire

// ==== verif/tb_adc_conversion_readout_ctrl.sv ====
`default_nettype none

module tb_adc_conversion_readout_ctrl
  import acrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************
  // Setup
  // ****************
  // Short counts keep the run small; conversion stays longer than a read
  localparam int HS  = 800;
  localparam int HR  = 1600;
  localparam int CAL = 1200;
  typedef struct packed {
    logic        fast;
    logic [31:0] smp;
    logic [23:0] exp;
  } acrc_row_t;
  logic                       clock, srst, hold_start, fast_mode, single_req, read_req, cal_req;
  logic signed [SAMPLE_W-1:0] sample_in;
  logic [RESULT_W-1:0]        read_data;
  logic                       read_valid, busy, ready_seen, converting, calibrating, powered_down;
  int                         errors = 0;
  int                         total_checks = 0;
  int                         n;
  acrc_row_t                  rows [7] = '{
    '{1'b1, 32'h00000000, 24'h000000}, '{1'b0, 32'h00000001, 24'h000001},
    '{1'b1, 32'hffffffff, 24'hffffff}, '{1'b0, 32'h00800000, 24'h7fffff},
    '{1'b1, 32'hff7fffff, 24'h800000}, '{1'b1, 32'h007fffff, 24'h7fffff},
    '{1'b0, 32'h005a3cc3, 24'h5a3cc3}};

  acrc_link_if link_if ();
  acrc_device #(.HS_CONV_CYCLES(HS), .HR_CONV_CYCLES(HR), .CAL_CYCLES(CAL)) acrc_device_inst (
    .clock(clock), .srst(srst), .link(link_if.dev), .sample_in(sample_in),
    .converting(converting), .calibrating(calibrating), .powered_down(powered_down));
  acrc_host acrc_host_inst (
    .clock(clock), .srst(srst), .link(link_if.host), .hold_start(hold_start),
    .fast_mode(fast_mode), .single_req(single_req), .read_req(read_req), .cal_req(cal_req),
    .read_data(read_data), .read_valid(read_valid), .busy(busy), .ready_seen(ready_seen));
  acrc_monitor #(.HS_CONV_CYCLES(HS), .HR_CONV_CYCLES(HR), .CAL_CYCLES(CAL)) acrc_monitor_inst (
    .clock(clock), .srst(srst), .start(link_if.start), .mode(link_if.mode),
    .sclk(link_if.sclk), .ready_and_serial_output(link_if.ready_and_serial_output));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ****************
  // Tasks
  // ****************
  task automatic tick(input int k);
    repeat (k) begin
      @(posedge clock);
      #2;
    end
  endtask : tick

  task automatic check_word(input string what, input logic [23:0] exp, input logic [23:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word

  task automatic check_bit(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  task automatic check_span(input string what, input int lo, input int hi, input int got);
    total_checks++;
    if (got < lo || got > hi) begin
      errors++;
      $display("FAIL %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : check_span

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask : pulse

  task automatic read_word(ref logic req);
    int k;
    k = 0;
    pulse(req);
    while (read_valid !== 1'b1 && k < 12000) begin
      tick(1);
      k++;
    end
    if (k >= 12000) check_bit("read done", 1'b1, 1'b0);
  endtask : read_word

  task automatic end_sim();
    if (errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (100000) @(posedge clock);
    errors++;
    end_sim();
  end

  // ****************
  // Tests
  // ****************
  initial begin
    {srst, hold_start, fast_mode, single_req, read_req, cal_req} = 6'h20;
    sample_in = 32'h00000005;
    tick(16);
    srst = 1'b0;
    tick(1);
    check_bit("calibrating", 1'b1, calibrating);
    read_word(read_req);
    check_word("power-up result", 24'h000005, read_data);
    foreach (rows[i]) begin
      fast_mode = rows[i].fast;
      sample_in = rows[i].smp;
      tick(2);
      pulse(single_req);
      n = 0;
      while (converting !== 1'b1 && n < 200) begin
        tick(1);
        n++;
      end
      n = 0;
      while (converting === 1'b1 && n < 5000) begin
        tick(1);
        n++;
      end
      if (rows[i].fast) check_span("fast conversion", HS, HS * 133 / 80, n);
      else check_span("slow conversion", HR, HR * 833 / 455, n);
      read_word(read_req);
      check_word("row result", rows[i].exp, read_data);
      tick(4);
      check_bit("pin forced high", 1'b1, link_if.ready_and_serial_output);
      check_bit("powered down", 1'b1, powered_down);
      check_bit("host idle", 1'b0, busy);
      check_bit("ready seen", 1'b0, ready_seen);
    end
    // Mode drops mid-run: the conversion under way keeps its latched speed
    hold_start = 1'b1;
    fast_mode  = 1'b1;
    sample_in  = 32'h00100000;
    for (int k = 0; k < 5; k++) begin
      if (k == 2) fast_mode = 1'b0;
      read_word(read_req);
      check_word("continuous result", 24'(32'h00100000 + k), read_data);
      sample_in = 32'h00100001 + k;
    end
    hold_start = 1'b0;
    tick(6000);
    check_bit("stopped", 1'b0, converting);
    check_bit("powered down", 1'b1, powered_down);
    check_bit("ready seen", 1'b1, ready_seen);
    sample_in = 32'h00654321;
    read_word(cal_req);
    check_bit("calibrating", 1'b1, calibrating);
    read_word(read_req);
    check_word("calibrated result", 24'h654321, read_data);
    srst = 1'b1;
    tick(16);
    srst = 1'b0;
    tick(1);
    check_bit("calibrating again", 1'b1, calibrating);
    read_word(read_req);
    check_word("second power-up", 24'h654321, read_data);
    end_sim();
  end
endmodule : tb_adc_conversion_readout_ctrl

`default_nettype wire
